/* File: rtl/crd_pin_filter.sv */
// three-flop pin synchroniser with an agreement hold filter
`timescale 1ns/100ps
module crd_pin_filter #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0,
  parameter int HOLD = 1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] level_d;
  logic [3:0] cnt_q [W];
  logic [3:0] cnt_d [W];

  // a new level counts only after HOLD agreeing cycles of stages two and three
  always_comb begin
    level_d = level_q;
    for (int i = 0; i < W; i++) begin
      cnt_d[i] = 4'h0;
      if (s2_q[i] == s3_q[i] && s3_q[i] != level_q[i]) begin
        if (cnt_q[i] == 4'(HOLD - 1)) begin
          level_d[i] = s3_q[i];
        end else begin
          cnt_d[i] = cnt_q[i] + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      level_q <= INIT;
      for (int i = 0; i < W; i++) begin
        cnt_q[i] <= 4'h0;
      end
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= level_d;
      for (int i = 0; i < W; i++) begin
        cnt_q[i] <= cnt_d[i];
      end
    end
  end
endmodule

/* File: rtl/crd_pkg.sv */
// constants, register map and types for the clock request decoder
package crd_pkg;
  localparam int NCH = 4;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // timing, clock at 10 MHz
  localparam int CLK_PERIOD_NS = 100;
  localparam int GLITCH_NS = 300;
  localparam int GLITCH_CYC = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_MIN_NS = 500;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_POLARITY = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_SW_REQ = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_PRIORITY = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_DRIVE = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 3'h5;

  // field positions
  localparam int PRIO_LSB = 0;
  localparam int LDO_OVR_BIT = 4;
  localparam int LDO_ON_BIT = 5;
  localparam int STAT_MREQ_BIT = 4;
  localparam int STAT_RST_BIT = 5;
  localparam int STAT_BATT_BIT = 6;
  localparam int STAT_ANA_BIT = 7;

  // reset values
  localparam logic [NCH-1:0] POLARITY_RST = 4'h0;
  localparam logic [NCH-1:0] SW_REQ_RST = 4'h9;
  localparam logic [NCH-1:0] PRIORITY_RST = 4'h9;
  localparam logic [NCH-1:0] FORCED_MASK = 4'h9;
  localparam logic [1:0] LDO_CTRL_RST = 2'h0;

  typedef enum logic [1:0] {
    CRD_WIRED_OR = 2'b00,
    CRD_WIRED_AND = 2'b01,
    CRD_PUSH_PULL = 2'b10
  } crd_drive_type;

  localparam crd_drive_type DRIVE_RST = CRD_WIRED_OR;
endpackage

/* File: rtl/crd_top.sv */
// clock request decoder: channel gating, master request, regulator enable
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
// Function
// - reset restores channel 1 and 4 bits
// - priority bit picks pin or software request
// - control port ignored while reset held
// - reset pulses near 300 ns are rejected
// - per-channel polarity bit sets request level
// - requests active-high after power-up
// - active-high: high request runs clock
// - active-low: low request runs clock
// - software may override regulator control
// - decoder regulator on while any request
// - regulator needs battery, core, request or reset
// - no analog supply: clock outputs high-impedance
// - core power-up restores every default
// - outputs 1 and 4 run by default
// - master request wired-OR, configurable otherwise
module crd_top (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic reset_pin_n,
  input wire logic [3:0] clock_request_inputs,
  input wire logic battery_supply_ok,
  input wire logic analog_supply_ok,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic [3:0] buffered_clock_outputs_run,
  output logic [3:0] buffered_clock_outputs_oe,
  output logic master_req_out,
  output logic master_req_oe,
  output logic regulator_output_en
);
  logic [3:0] req_s;
  logic batt_s;
  logic ana_s;
  logic rst_pin_s;
  logic periph_rst;
  logic [3:0] active;
  logic any_active;

  // control registers
  logic [3:0] polarity_q;
  logic [3:0] polarity_d;
  logic [3:0] software_request_bits_q;
  logic [3:0] software_request_bits_d;
  logic [3:0] priority_q;
  logic [3:0] priority_d;
  logic [1:0] ldo_ctrl_q;
  logic [1:0] ldo_ctrl_d;
  crd_pkg::crd_drive_type drive_q;
  crd_pkg::crd_drive_type drive_d;
  logic [7:0] rdata_d;

  // output flops
  logic [3:0] run_d;
  logic [3:0] oe_d;
  logic mreq_d;
  logic mreq_q;
  logic mout_d;
  logic moe_d;
  logic ldo_d;

  // a request counts as active when it differs from its polarity bit
  function automatic logic [3:0] active_of(input logic [3:0] req, input logic [3:0] pol);
    active_of = req ^ pol;
  endfunction

  crd_pin_filter #(
    .W(1),
    .INIT(1'b1),
    .HOLD(crd_pkg::GLITCH_CYC)
  ) u_rst_filter (
    .clock(clock),
    .rst_n(rst_n),
    .pin_in(reset_pin_n),
    .level_q(rst_pin_s)
  );

  // requests and supply detects need only the plain synchroniser
  crd_pin_filter #(
    .W(6),
    .INIT(6'h00),
    .HOLD(1)
  ) u_pin_sync (
    .clock(clock),
    .rst_n(rst_n),
    .pin_in({analog_supply_ok, battery_supply_ok, clock_request_inputs}),
    .level_q({ana_s, batt_s, req_s})
  );

  assign periph_rst = ~rst_pin_s;
  assign active = active_of(req_s, polarity_q);
  assign any_active = |active;

  // register writes and peripheral reset forcing
  always_comb begin
    polarity_d = polarity_q;
    software_request_bits_d = software_request_bits_q;
    priority_d = priority_q;
    ldo_ctrl_d = ldo_ctrl_q;
    drive_d = drive_q;
    if (reg_wr && !periph_rst) begin
      if (reg_addr == crd_pkg::OFS_POLARITY) begin
        polarity_d = reg_wdata[3:0];
      end else if (reg_addr == crd_pkg::OFS_SW_REQ) begin
        software_request_bits_d = reg_wdata[3:0];
      end else if (reg_addr == crd_pkg::OFS_PRIORITY) begin
        priority_d = reg_wdata[crd_pkg::PRIO_LSB +: 4];
        ldo_ctrl_d = {reg_wdata[crd_pkg::LDO_ON_BIT], reg_wdata[crd_pkg::LDO_OVR_BIT]};
      end else if (reg_addr == crd_pkg::OFS_DRIVE) begin
        // reserved code keeps the previous mode
        if (reg_wdata[1:0] != 2'b11) begin
          drive_d = crd_pkg::crd_drive_type'(reg_wdata[1:0]);
        end
      end
    end
    // force channels 1 and 4 on
    if (periph_rst) begin
      priority_d = priority_d | crd_pkg::FORCED_MASK;
      software_request_bits_d = software_request_bits_d | crd_pkg::FORCED_MASK;
    end
  end

  // register reads, data valid only in the cycle after the strobe
  always_comb begin
    rdata_d = 8'h00;
    if (reg_rd && !periph_rst) begin
      if (reg_addr == crd_pkg::OFS_POLARITY) begin
        rdata_d = {4'h0, polarity_q};
      end else if (reg_addr == crd_pkg::OFS_SW_REQ) begin
        rdata_d = {4'h0, software_request_bits_q};
      end else if (reg_addr == crd_pkg::OFS_PRIORITY) begin
        rdata_d = {2'h0, ldo_ctrl_q[1], ldo_ctrl_q[0], priority_q};
      end else if (reg_addr == crd_pkg::OFS_DRIVE) begin
        rdata_d = {6'h00, drive_q};
      end else if (reg_addr == crd_pkg::OFS_STATUS) begin
        rdata_d = {ana_s, batt_s, periph_rst, mreq_q, active};
      end
    end
  end

  // channel gating, master request and regulator
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      run_d[i] = ana_s & (priority_q[i] ? software_request_bits_q[i] : active[i]);
      oe_d[i] = ana_s;
    end
    // master request follows any active pin
    mreq_d = any_active;
    case (drive_q)
      crd_pkg::CRD_WIRED_AND: begin
        mout_d = 1'b0;
        moe_d = ~mreq_d;
      end
      crd_pkg::CRD_PUSH_PULL: begin
        mout_d = mreq_d;
        moe_d = 1'b1;
      end
      default: begin
        mout_d = 1'b1;
        moe_d = mreq_d;
      end
    endcase
    if (ldo_ctrl_q[0]) begin
      ldo_d = batt_s & ldo_ctrl_q[1];
    end else begin
      ldo_d = batt_s & (any_active | periph_rst);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      polarity_q <= crd_pkg::POLARITY_RST;
      software_request_bits_q <= crd_pkg::SW_REQ_RST;
      priority_q <= crd_pkg::PRIORITY_RST;
      ldo_ctrl_q <= crd_pkg::LDO_CTRL_RST;
      drive_q <= crd_pkg::DRIVE_RST;
      reg_rdata <= 8'h00;
      buffered_clock_outputs_run <= 4'h0;
      buffered_clock_outputs_oe <= 4'h0;
      mreq_q <= 1'b0;
      master_req_out <= 1'b1;
      master_req_oe <= 1'b0;
      regulator_output_en <= 1'b0;
    end else begin
      polarity_q <= polarity_d;
      software_request_bits_q <= software_request_bits_d;
      priority_q <= priority_d;
      ldo_ctrl_q <= ldo_ctrl_d;
      drive_q <= drive_d;
      reg_rdata <= rdata_d;
      buffered_clock_outputs_run <= run_d;
      buffered_clock_outputs_oe <= oe_d;
      mreq_q <= mreq_d;
      master_req_out <= mout_d;
      master_req_oe <= moe_d;
      regulator_output_en <= ldo_d;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  a_reset_forces_ch14: assert property (
    periph_rst |=> (priority_q[0] && priority_q[3]
      && software_request_bits_q[0] && software_request_bits_q[3]))
    else $error("reset did not force channels 1 and 4");

  a_reset_keeps_mid: assert property (
    periph_rst |=> software_request_bits_q[2:1] == $past(software_request_bits_q[2:1])
      && priority_q[2:1] == $past(priority_q[2:1]))
    else $error("reset altered channel 2 or 3 bits");

  a_write_blocked: assert property (
    (periph_rst && reg_wr) |=> polarity_q == $past(polarity_q) && drive_q == $past(drive_q)
      && ldo_ctrl_q == $past(ldo_ctrl_q))
    else $error("write accepted during reset");

  a_read_blocked: assert property (
    (periph_rst && reg_rd) |=> reg_rdata == 8'h00)
    else $error("read answered during reset");

  a_short_glitch: assert property (
    (rst_pin_s && reset_pin_n) [*4] ##1 !reset_pin_n [*3] ##1 reset_pin_n
      |-> rst_pin_s [*6])
    else $error("three-cycle reset glitch took effect");

  a_polarity_write: assert property (
    (reg_wr && !periph_rst && reg_addr == crd_pkg::OFS_POLARITY)
      |=> polarity_q == $past(reg_wdata[3:0]))
    else $error("polarity write lost");

  a_sw_select: assert property (
    (ana_s && priority_q[1] && software_request_bits_q[1])
      |=> buffered_clock_outputs_run[1])
    else $error("software request did not run channel 2");

  a_pin_select: assert property (
    (ana_s && !priority_q[2]) |=> buffered_clock_outputs_run[2] == $past(active[2]))
    else $error("channel 3 did not follow its pin");

  a_master_idle: assert property (
    (active_of(req_s, polarity_q) == 4'h0) |=> !mreq_q)
    else $error("master request high with no active request");

  a_master_any: assert property (
    (req_s[3] != polarity_q[3]) |=> mreq_q)
    else $error("master request low with channel 4 active");

  a_ldo_battery: assert property (
    regulator_output_en |-> $past(batt_s))
    else $error("regulator on without battery");

  a_ldo_decoder: assert property (
    (!ldo_ctrl_q[0] && batt_s && any_active) |=> regulator_output_en)
    else $error("decoder left regulator off");

  a_analog_hiz: assert property (
    !ana_s |=> buffered_clock_outputs_oe == 4'h0 && buffered_clock_outputs_run == 4'h0)
    else $error("clock outputs driven without analog supply");

  a_wired_or: assert property (
    (drive_q == crd_pkg::CRD_WIRED_OR) |=> !(master_req_oe && !master_req_out))
    else $error("wired-OR pin driven low");

  a_wired_and: assert property (
    (drive_q == crd_pkg::CRD_WIRED_AND) |=> !(master_req_oe && master_req_out))
    else $error("wired-AND pin driven high");

  a_push_pull: assert property (
    (drive_q == crd_pkg::CRD_PUSH_PULL)
      |=> master_req_oe && master_req_out == $past(any_active))
    else $error("push-pull pin not following request");

  a_ldo_override: assert property (
    ldo_ctrl_q[0] |=> regulator_output_en == $past(batt_s && ldo_ctrl_q[1]))
    else $error("software regulator control ignored");

  a_ldo_idle_off: assert property (
    (!ldo_ctrl_q[0] && !any_active && !periph_rst) |=> !regulator_output_en)
    else $error("decoder left regulator on with no request");

  a_ldo_in_reset: assert property (
    (!ldo_ctrl_q[0] && batt_s && periph_rst) |=> regulator_output_en)
    else $error("regulator off during peripheral reset");

  a_analog_drive: assert property (
    ana_s |=> buffered_clock_outputs_oe == 4'hF)
    else $error("clock outputs floating with analog supply");

  a_forced_run: assert property (
    (ana_s && priority_q[0] && priority_q[3]
      && software_request_bits_q[0] && software_request_bits_q[3])
      |=> buffered_clock_outputs_run[0] && buffered_clock_outputs_run[3])
    else $error("channel 1 or 4 not running while forced");
endmodule

/* File: tb/crd_far_model.sv */
// far-side model: peripherals on the request pins, master source on its wire
`timescale 1ns/100ps
module crd_far_model (
  input wire logic clock,
  input wire logic [3:0] want_level,
  input wire logic pull_up,
  input wire logic master_req_out,
  input wire logic master_req_oe,
  output logic [3:0] clock_request_inputs,
  output logic master_level
);
  // pins move a cycle late, out of step with the bench stimulus
  always @(posedge clock) begin
    clock_request_inputs <= want_level;
  end
  assign master_level = master_req_oe ? master_req_out : pull_up;
endmodule

/* File: tb/tb_crd_top.sv */
// self-checking bench for the clock request decoder
`timescale 1ns/100ps
module tb_crd_top;
  logic clock = 0, rst_n = 0, reset_pin_n = 1, batt = 0, ana = 0, pull_up = 0;
  logic reg_wr = 0, reg_rd = 0, rd_d = 0, snap = 0, ovr_m, on_m;
  logic mreq_out, mreq_oe, reg_en, mlevel;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic [3:0] run, oe, req_pins, pol_m, prio_m, sw_m, pins = 4'h0;
  logic [1:0] drv_m;
  logic [31:0] seed = 32'h37, r;
  logic [7:0] q_rd[$];
  logic [11:0] q_out[$];
  int n_errors = 0, num_checks = 0;

  always #50 clock = ~clock;

  crd_far_model far (.clock(clock), .want_level(pins), .pull_up(pull_up),
    .master_req_out(mreq_out), .master_req_oe(mreq_oe),
    .clock_request_inputs(req_pins), .master_level(mlevel));
  crd_top uut (.clock(clock), .rst_n(rst_n), .reset_pin_n(reset_pin_n),
    .clock_request_inputs(req_pins), .battery_supply_ok(batt), .analog_supply_ok(ana),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .buffered_clock_outputs_run(run),
    .buffered_clock_outputs_oe(oe), .master_req_out(mreq_out),
    .master_req_oe(mreq_oe), .regulator_output_en(reg_en));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // outputs, master pin pair, wire level, regulator
  function automatic logic [11:0] model(input logic prst);
    logic [3:0] act;
    logic any;
    logic [1:0] mp;
    act = pins ^ pol_m;
    any = |act;
    mp = (drv_m == 2'h0) ? {1'b1, any} : (drv_m == 2'h1) ? {1'b0, ~any} : {any, 1'b1};
    return {{4{ana}} & ((prio_m & sw_m) | (~prio_m & act)), {4{ana}}, mp, any,
      batt & (ovr_m ? on_m : (any | prst))};
  endfunction

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t read got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk12(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t outputs got %h exp %h", $time, got, exp);
    end
  endtask

  // one strobe cycle, then an idle cycle so strobes never toggle twice in a step
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    q_rd.push_back(e);
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
  endtask

  task automatic look(input logic prst);
    q_out.push_back(model(prst));
    snap <= 1'b1;
    @(posedge clock);
    snap <= 1'b0;
  endtask

  task automatic defaults();
    pol_m = 4'h0;
    sw_m = 4'h9;
    prio_m = 4'h9;
    drv_m = 2'h0;
    ovr_m = 1'b0;
    on_m = 1'b0;
    rd(3'h0, 8'h00);
    rd(3'h1, 8'h09);
    rd(3'h2, 8'h09);
    rd(3'h4, 8'h00);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    rd_d <= reg_rd;
    if (rd_d) chk8(reg_rdata, q_rd.pop_front());
    if (snap) chk12({run, oe, mreq_out, mreq_oe, mlevel, reg_en}, q_out.pop_front());
  end

  initial begin
    repeat (5000) @(posedge clock);
    n_errors++;
    tally_and_finish();
  end

  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    ana <= 1'b1;
    batt <= 1'b1;
    repeat (2) @(posedge clock);
    defaults();
    rd(3'h3, 8'h00);
    repeat (8) @(posedge clock);
    look(1'b0);
    for (int i = 0; i < 24; i++) begin
      r = xs();
      pins <= r[3:0];
      pol_m = r[7:4];
      prio_m = r[11:8];
      sw_m = r[15:12];
      ovr_m = r[16];
      on_m = r[17];
      batt <= r[18] | r[21];
      ana <= r[19] | r[20];
      wr(3'h0, {4'h0, pol_m});
      wr(3'h1, {4'h0, sw_m});
      wr(3'h2, {2'h0, on_m, ovr_m, prio_m});
      // code 3 is refused, the previous mode stays
      wr(3'h4, {6'h00, i[1:0]});
      if (i[1:0] != 2'h3) drv_m = i[1:0];
      pull_up <= (drv_m == 2'h1);
      repeat (8) @(posedge clock);
      look(1'b0);
      rd(3'h4, {6'h00, drv_m});
      rd(3'h5, {ana, batt, 1'b0, |(pins ^ pol_m), pins ^ pol_m});
      rd(3'h2, {2'h0, on_m, ovr_m, prio_m});
    end
    pins <= 4'h0;
    pull_up <= 1'b0;
    batt <= 1'b1;
    ana <= 1'b1;
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h06);
    wr(3'h2, 8'h06);
    wr(3'h4, 8'h00);
    // a short low spike must leave the channel bits alone
    reset_pin_n <= 1'b0;
    repeat (3) @(posedge clock);
    reset_pin_n <= 1'b1;
    repeat (8) @(posedge clock);
    rd(3'h2, 8'h06);
    // low held well beyond the minimum width
    reset_pin_n <= 1'b0;
    repeat (8) @(posedge clock);
    wr(3'h0, 8'h0F);
    // forced software bits would read back nonzero if the read got through
    rd(3'h1, 8'h00);
    pol_m = 4'h0;
    prio_m = 4'hF;
    sw_m = 4'hF;
    drv_m = 2'h0;
    ovr_m = 1'b0;
    look(1'b1);
    reset_pin_n <= 1'b1;
    repeat (10) @(posedge clock);
    rd(3'h0, 8'h00);
    rd(3'h1, 8'h0F);
    rd(3'h2, 8'h0F);
    rst_n <= 1'b0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    defaults();
    tally_and_finish();
  end
endmodule
